//--- src/abu_pkg.sv
// package: constants, register map and carrier types of the address breakpoint unit
// Operation
// R01 - enabled breaks raise a request when the bus address equals the breakpoint
// R02 - only program counter addresses are compared for triggering
// R03 - core loads the software interrupt opcode after the current instruction
// R04 - break vector is $FFFC/$FFFD, or $FEFC/$FEFD in monitor mode
// R05 - match on an instruction's last cycle starts the break at once
// R06 - software writing one to the active flag forces a break
// R07 - return from interrupt in the handler ends the break state
// R08 - timer counter is stopped while a break is in progress
// R09 - watchdog is disabled in a break only with high test voltage present
// R10 - flag clear enable decides if status bits clear during break
// R11 - logic runs in wait mode; wait exit by break is recorded
// R12 - software may decrement the stacked return address after a wait exit
// R13 - logic inactive in stop mode; registers keep their contents
// R14 - status bit 7 is the read/write match enable, cleared by reset
// R15 - active flag set on match, cleared by reset; software writes zero
// R16 - two byte registers hold address bits 15:8 and 7:0, reset zero
// R17 - status bits 5 to 0 read as zero and ignore writes
package abu_pkg;
   // ==========================================
   // register map, byte addresses
   localparam logic [15:0] ADDR_STATUS_CONTROL = 16'hfe0b;
   localparam logic [15:0] ADDR_BRK_HIGH = 16'hfe0c;
   localparam logic [15:0] ADDR_BRK_LOW = 16'hfe0d;
   localparam logic [15:0] ADDR_FLAG_CONTROL = 16'hfe0e;
   localparam logic [15:0] ADDR_IRQ_STATUS = 16'hfe10;
   localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hfe14;
   localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hfe18;
   localparam logic [15:0] ADDR_WAIT_STATUS = 16'hfe1c;
   // ==========================================
   // fields and reset values
   localparam int BIT_MATCH_ENABLE = 7;
   localparam int BIT_ACTIVE = 6;
   localparam int BIT_FLAG_CLEAR_ENABLE = 7;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int IRQ_BITS = 3;
   localparam int IRQ_MATCH = 0;
   localparam int IRQ_FORCED = 1;
   localparam int IRQ_END = 2;
   localparam logic [15:0] VECTOR_USER = 16'hfffc;
   localparam logic [15:0] VECTOR_MONITOR = 16'hfefc;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ==========================================
   // break sequencer states
   typedef enum logic [2:0] {
      ABU_IDLE = 3'b001,
      ABU_PENDING = 3'b010,
      ABU_ACTIVE = 3'b100
   } abu_state_t;
   // ==========================================
   // core-side carriers
   typedef struct packed {
      logic [15:0] address;
      logic pc_fetch;
      logic last_cycle;
      logic rti_done;
      logic wait_mode;
      logic stop_mode;
      logic monitor_mode;
      logic high_test_voltage;
   } abu_core_in_t;
   typedef struct packed {
      logic break_request;
      logic [15:0] break_vector;
      logic timer_stop;
      logic watchdog_disable;
   } abu_core_out_t;
endpackage : abu_pkg

//--- src/abu_match.sv
// address comparator for the breakpoint unit
`timescale 1ns/10ps
module abu_match #(
   parameter int ADDR_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [ADDR_W-1:0] breakpoint,
   input wire logic qualify,
   output logic hit
);
   logic [ADDR_W-1:0] bit_eq;
   // ==========================================
   // per-bit compare
   for (genvar i = 0; i < ADDR_W; i++) begin : g_eq
      assign bit_eq[i] = ~(address[i] ^ breakpoint[i]);
   end
   // registered so the compare does not sit in the core's address path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit <= 1'b0;
      end else begin
         hit <= qualify & (&bit_eq); // see R01
      end
   end
endmodule : abu_match

//--- src/abu_top.sv
// address breakpoint unit with AXI4-Lite register slave
`timescale 1ns/10ps
module abu_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [15:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire abu_pkg::abu_core_in_t core_in,
   output abu_pkg::abu_core_out_t core_out,
   output logic irq
);
   import abu_pkg::*;

   // ==========================================
   // state
   abu_state_t state;
   abu_state_t next_state;
   logic match_break_enable;
   logic break_active_flag;
   logic flag_clear_enable;
   logic wait_exit_indicator;
   logic [7:0] breakpoint_address_high;
   logic [7:0] breakpoint_address_low;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_enable;
   logic [IRQ_BITS-1:0] irq_event;
   logic [IRQ_BITS-1:0] irq_clear;
   logic raw_hit;
   logic hit;
   logic in_break;
   logic forced;
   logic break_start;
   logic break_end;

   // ==========================================
   // bus write side
   logic [15:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic do_write;
   logic wr_ok;
   logic [7:0] wbyte;

   // aw and w may arrive in either order; each is parked until both are held
   assign do_write = aw_held & w_held & ~s_bvalid;
   assign wbyte = w_data[7:0];
   assign wr_ok = w_strb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 16'h0000;
         s_awready <= 1'b0;
      end else if (s_awvalid && s_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_awaddr;
         s_awready <= 1'b0;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else begin
         s_awready <= ~aw_held & ~s_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_wready <= 1'b0;
      end else if (s_wvalid && s_wready) begin
         w_held <= 1'b1;
         w_data <= s_wdata;
         w_strb <= s_wstrb;
         s_wready <= 1'b0;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else begin
         s_wready <= ~w_held & ~s_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         unique case (aw_addr)
            ADDR_STATUS_CONTROL, ADDR_BRK_HIGH, ADDR_BRK_LOW, ADDR_FLAG_CONTROL,
            ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE, ADDR_WAIT_STATUS: begin
               s_bresp <= RESP_OKAY;
            end
            default: begin
               s_bresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // ==========================================
   // registers written by software
   logic wr_sc;
   assign wr_sc = do_write && wr_ok && aw_addr == ADDR_STATUS_CONTROL;
   logic wr_flag_control;
   logic wr_irq_clear;
   logic wr_irq_enable;
   logic wr_wait_status;
   assign wr_flag_control = do_write && wr_ok && aw_addr == ADDR_FLAG_CONTROL;
   assign wr_irq_clear = do_write && wr_ok && aw_addr == ADDR_IRQ_CLEAR;
   assign wr_irq_enable = do_write && wr_ok && aw_addr == ADDR_IRQ_ENABLE;
   assign wr_wait_status = do_write && wr_ok && aw_addr == ADDR_WAIT_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_break_enable <= 1'b0; // see R14
      end else if (wr_sc) begin
         match_break_enable <= wbyte[BIT_MATCH_ENABLE]; // see R14
      end
   end

   // address registers keep their value through stop mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         breakpoint_address_high <= RESET_BYTE; // see R16
         breakpoint_address_low <= RESET_BYTE; // see R16
      end else if (do_write && wr_ok) begin
         if (aw_addr == ADDR_BRK_HIGH) begin
            breakpoint_address_high <= wbyte; // see R16
         end
         if (aw_addr == ADDR_BRK_LOW) begin
            breakpoint_address_low <= wbyte; // see R16
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_clear_enable <= 1'b0;
      end else if (wr_flag_control) begin
         flag_clear_enable <= wbyte[BIT_FLAG_CLEAR_ENABLE];
      end
   end

   // ==========================================
   // match path
   abu_match #(
      .ADDR_W(16)
   ) u_match (
      .aclk(aclk),
      .aresetn(aresetn),
      .address(core_in.address),
      .breakpoint({breakpoint_address_high, breakpoint_address_low}),
      .qualify(match_break_enable & core_in.pc_fetch & ~core_in.stop_mode), // see R02 see R13
      .hit(raw_hit)
   );
   // a hit seen after stop entry is dropped; the compare runs one cycle late
   assign hit = raw_hit & ~core_in.stop_mode; // see R13
   // the stopped core cannot take a break, so a forced one is dropped as well
   assign forced = wr_sc & wbyte[BIT_ACTIVE] & ~core_in.stop_mode; // see R06 see R13
   assign in_break = state != ABU_IDLE;
   assign break_start = (state == ABU_IDLE) & (hit | forced);
   assign break_end = (state == ABU_ACTIVE) & core_in.rti_done; // see R07

   // active flag: set wins over a software clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         break_active_flag <= 1'b0; // see R15
      end else if (hit || forced) begin
         break_active_flag <= 1'b1; // see R15 see R06
      end else if (wr_sc && !wbyte[BIT_ACTIVE]) begin
         break_active_flag <= 1'b0; // see R15
      end
   end

   // ==========================================
   // break sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         ABU_IDLE: begin
            if (hit || forced) begin
               // last-cycle match goes straight to the break
               next_state = core_in.last_cycle ? ABU_ACTIVE : ABU_PENDING; // see R05
            end
         end
         ABU_PENDING: begin
            if (core_in.last_cycle) begin
               next_state = ABU_ACTIVE; // see R03
            end
         end
         ABU_ACTIVE: begin
            if (core_in.rti_done) begin
               next_state = ABU_IDLE; // see R07
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ABU_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // the vector tracks the mode every cycle, so it is settled before the core fetches it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_out <= '0;
      end else begin
         core_out.break_request <= next_state != ABU_IDLE; // see R01
         core_out.break_vector <= core_in.monitor_mode ? VECTOR_MONITOR : VECTOR_USER; // see R04
         core_out.timer_stop <= next_state == ABU_ACTIVE; // see R08
         core_out.watchdog_disable <= (next_state == ABU_ACTIVE) & core_in.high_test_voltage; // see R09
      end
   end

   // wait exit through a break is remembered until software clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_exit_indicator <= 1'b0;
      end else if (break_start && core_in.wait_mode) begin
         wait_exit_indicator <= 1'b1; // see R11
      end else if (wr_wait_status && !wbyte[0]) begin
         wait_exit_indicator <= 1'b0;
      end
   end

   // ==========================================
   // interrupt status
   // match and forced events are taken only from idle, so a hit inside a break raises no new status
   assign irq_event[IRQ_MATCH] = hit & (state == ABU_IDLE);
   assign irq_event[IRQ_FORCED] = forced & (state == ABU_IDLE);
   assign irq_event[IRQ_END] = break_end;
   // status clears are blocked during a break unless enabled
   assign irq_clear = (wr_irq_clear && (!in_break || flag_clear_enable)) ? wbyte[IRQ_BITS-1:0] : '0; // see R10

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= irq_event | (irq_status & ~irq_clear);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable <= '0;
      end else if (wr_irq_enable) begin
         irq_enable <= wbyte[IRQ_BITS-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_event | (irq_status & ~irq_clear)) & irq_enable);
      end
   end

   // ==========================================
   // bus read side
   logic [7:0] rbyte;
   logic rd_known;
   always_comb begin
      // unimplemented bits and the write-only clear read back as zero
      rbyte = 8'h00; // see R17
      rd_known = 1'b1;
      unique case (s_araddr)
         ADDR_STATUS_CONTROL: begin
            rbyte[BIT_MATCH_ENABLE] = match_break_enable; // see R14
            rbyte[BIT_ACTIVE] = break_active_flag; // see R15
         end
         ADDR_BRK_HIGH: begin
            rbyte = breakpoint_address_high;
         end
         ADDR_BRK_LOW: begin
            rbyte = breakpoint_address_low;
         end
         ADDR_FLAG_CONTROL: begin
            rbyte[BIT_FLAG_CLEAR_ENABLE] = flag_clear_enable;
         end
         ADDR_IRQ_STATUS: begin
            rbyte[IRQ_BITS-1:0] = irq_status;
         end
         ADDR_IRQ_CLEAR: begin
            rbyte = 8'h00;
         end
         ADDR_IRQ_ENABLE: begin
            rbyte[IRQ_BITS-1:0] = irq_enable;
         end
         ADDR_WAIT_STATUS: begin
            rbyte[0] = wait_exit_indicator;
         end
         default: begin
            rd_known = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rdata <= {24'h00_0000, rbyte};
         s_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid) begin
         if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end else begin
         s_arready <= 1'b1;
      end
   end
endmodule : abu_top

//--- verif/abu_assertions.sv
// concurrent checks on the breakpoint unit ports
`timescale 1ns/10ps
module abu_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic [1:0] s_bresp,
   input wire abu_pkg::abu_core_in_t core_in,
   input wire abu_pkg::abu_core_out_t core_out
);
   import abu_pkg::*;
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // break sequencing and write response hold
   sequence ends_s;
      core_out.timer_stop && core_in.rti_done;
   endsequence
   sequence pend_s;
      core_out.break_request && !core_out.timer_stop;
   endsequence
   timer_in_break_a: assert property (core_out.timer_stop |-> core_out.break_request)
      else $error("timer stop outside a break");
   watchdog_gate_a: assert property (
      core_out.watchdog_disable == (core_out.timer_stop && $past(core_in.high_test_voltage)))
      else $error("watchdog disable wrong");
   vector_pick_a: assert property (core_out.break_request |->
      core_out.break_vector == ($past(core_in.monitor_mode) ? VECTOR_MONITOR : VECTOR_USER))
      else $error("break vector wrong");
   rti_ends_a: assert property (ends_s |=> !core_out.break_request && !core_out.timer_stop)
      else $error("break did not end");
   request_holds_a: assert property (core_out.break_request && !core_in.rti_done |=> core_out.break_request)
      else $error("break request dropped");
   last_cycle_go_a: assert property (pend_s ##0 core_in.last_cycle |=> core_out.timer_stop)
      else $error("break did not start on last cycle");
   pending_waits_a: assert property (pend_s ##0 !core_in.last_cycle |=> !core_out.timer_stop)
      else $error("break started mid instruction");
   stop_idle_a: assert property (core_in.stop_mode && $past(core_in.stop_mode) && !core_out.break_request
      |=> !core_out.break_request)
      else $error("break raised in stop mode");
   bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response not held");
endmodule : abu_checker
bind abu_top abu_checker abu_checker_i (.aclk(aclk), .aresetn(aresetn), .s_bvalid(s_bvalid),
   .s_bready(s_bready), .s_bresp(s_bresp), .core_in(core_in), .core_out(core_out));

//--- verif/abu_core_model.sv
// behavioural processor core facing the breakpoint unit
`timescale 1ns/10ps
module abu_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic leave,
   input wire abu_pkg::abu_core_in_t tb_in,
   input wire abu_pkg::abu_core_out_t core_out,
   output abu_pkg::abu_core_in_t core_in
);
   import abu_pkg::*;
   logic [1:0] cnt;
   logic done;
   // slow gives three-cycle instructions so a pending break has to wait
   always_ff @(posedge aclk) begin
      if (!aresetn || cnt == 2'h0) begin
         cnt <= slow ? 2'h2 : 2'h0;
      end else begin
         cnt <= cnt - 2'h1;
      end
   end
   // one return per break, even if leave stays high
   always_ff @(posedge aclk) begin
      if (!aresetn || !core_out.timer_stop) begin
         done <= 1'b0;
      end else if (leave) begin
         done <= 1'b1;
      end
   end
   always_comb begin
      core_in = tb_in;
      core_in.last_cycle = (cnt == 2'h0);
      core_in.rti_done = core_out.timer_stop && leave && !done;
   end
endmodule : abu_core_model

//--- verif/testbench.sv
// self-checking bench for the breakpoint unit
`timescale 1ns/10ps
module testbench;
   import abu_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
   logic slow, leave;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   abu_core_in_t tb_in, core_in;
   abu_core_out_t core_out;
   int error_cnt, check_count;
   abu_top abu_top_i (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
      .core_in(core_in), .core_out(core_out), .irq(irq));
   abu_core_model abu_core_model_i (.aclk(aclk), .aresetn(aresetn), .slow(slow), .leave(leave),
      .tb_in(tb_in), .core_out(core_out), .core_in(core_in));
   always #2 aclk = ~aclk;
   // ==========================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic results;
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= 4'h1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready && arvalid) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rresp", 32'(rresp), 32'(er));
      if (er == RESP_OKAY) chk($sformatf("read %h", a), rdata, {24'h000000, d});
   endtask : rd
   // one fetch of address a, then the bus moves on
   task automatic pc(input logic [15:0] a, input logic f);
      @(posedge aclk);
      tb_in.address <= a;
      tb_in.pc_fetch <= f;
      @(posedge aclk);
      tb_in.address <= ~a;
      repeat (4) @(posedge aclk);
   endtask : pc
   task automatic wt(input bit ts, input logic v);
      for (int n = 0; n < 20 && (ts ? core_out.timer_stop : core_out.break_request) !== v; n++) @(posedge aclk);
      chk("break wait", 32'(ts ? core_out.timer_stop : core_out.break_request), 32'(v));
   endtask : wt
   task automatic brk_end;
      wr(ADDR_STATUS_CONTROL, 8'h80);
      leave <= 1'b1;
      wt(1'b0, 1'b0);
      leave <= 1'b0;
      chk("timer_stop", 32'(core_out.timer_stop), 32'h0);
      wr(ADDR_IRQ_CLEAR, 8'h07);
   endtask : brk_end
   // ==========================================
   // tests
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, slow, leave} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      tb_in = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_STATUS_CONTROL, 8'h00);
      rd(ADDR_BRK_HIGH, 8'h00);
      rd(ADDR_BRK_LOW, 8'h00);
      wr(ADDR_STATUS_CONTROL, 8'h3f);
      rd(ADDR_STATUS_CONTROL, 8'h00);
      wr(16'hfe20, 8'hff, RESP_SLVERR);
      rd(16'hfe20, 8'h00, RESP_SLVERR);
      wr(ADDR_BRK_HIGH, 8'h12);
      wr(ADDR_BRK_LOW, 8'h34);
      rd(ADDR_BRK_HIGH, 8'h12);
      rd(ADDR_BRK_LOW, 8'h34);
      wr(ADDR_IRQ_ENABLE, 8'h07);
      pc(16'h1234, 1'b1);
      chk("no break disabled", 32'(core_out.break_request), 32'h0);
      wr(ADDR_STATUS_CONTROL, 8'h80);
      rd(ADDR_STATUS_CONTROL, 8'h80);
      pc(16'h1234, 1'b0);
      chk("no break data", 32'(core_out.break_request), 32'h0);
      pc(16'h1235, 1'b1);
      chk("no break other", 32'(core_out.break_request), 32'h0);
      tb_in.stop_mode <= 1'b1;
      pc(16'h1234, 1'b1);
      chk("no break stop", 32'(core_out.break_request), 32'h0);
      tb_in.stop_mode <= 1'b0;
      rd(ADDR_STATUS_CONTROL, 8'h80);
      slow <= 1'b1;
      tb_in.high_test_voltage <= 1'b1;
      pc(16'h1234, 1'b1);
      chk("break", 32'(core_out.break_request), 32'h1);
      chk("vector user", 32'(core_out.break_vector), 32'(VECTOR_USER));
      rd(ADDR_STATUS_CONTROL, 8'hc0);
      rd(ADDR_IRQ_STATUS, 8'h01);
      chk("irq", 32'(irq), 32'h1);
      wt(1'b1, 1'b1);
      chk("watchdog", 32'(core_out.watchdog_disable), 32'h1);
      wr(ADDR_IRQ_CLEAR, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h01);
      wr(ADDR_FLAG_CONTROL, 8'h80);
      wr(ADDR_IRQ_CLEAR, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h00);
      chk("irq clear", 32'(irq), 32'h0);
      brk_end;
      rd(ADDR_STATUS_CONTROL, 8'h80);
      slow <= 1'b0;
      tb_in.high_test_voltage <= 1'b0;
      tb_in.monitor_mode <= 1'b1;
      wr(ADDR_STATUS_CONTROL, 8'hc0);
      rd(ADDR_IRQ_STATUS, 8'h02);
      chk("forced", 32'(core_out.break_request), 32'h1);
      chk("vector", 32'(core_out.break_vector), 32'(VECTOR_MONITOR));
      wt(1'b1, 1'b1);
      chk("watchdog low", 32'(core_out.watchdog_disable), 32'h0);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      rd(ADDR_IRQ_ENABLE, 8'h00);
      chk("irq masked", 32'(irq), 32'h0);
      wr(ADDR_IRQ_ENABLE, 8'h07);
      rd(ADDR_IRQ_ENABLE, 8'h07);
      chk("irq unmasked", 32'(irq), 32'h1);
      brk_end;
      tb_in.monitor_mode <= 1'b0;
      tb_in.wait_mode <= 1'b1;
      pc(16'h1234, 1'b1);
      chk("wait break", 32'(core_out.break_request), 32'h1);
      rd(ADDR_WAIT_STATUS, 8'h01);
      tb_in.wait_mode <= 1'b0;
      brk_end;
      wr(ADDR_WAIT_STATUS, 8'h00);
      rd(ADDR_WAIT_STATUS, 8'h00);
      results();
   end
   initial begin
      #20000;
      error_cnt++;
      results();
   end
endmodule : testbench
